// ==== verilog/srpc_top.sv ====
module srpc_top
    import srpc_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    input  wire logic        SENSOR_0,
    input  wire logic        SENSOR_1,
    input  wire logic        WDOG_STOP,
    output logic      [3:0]  PHASE_OUT,
    output logic             IRQ
);
    logic        wr_pend_q;
    logic        rd_wait_q;
    logic [7:0]  addr_q;
    logic [31:0] rdata_q;
    logic [7:0]  ctrl_q;
    logic [15:0] steps_q;
    logic [7:0]  extra_q;
    logic [15:0] period_q;
    logic [7:0]  ramp_q;
    logic [7:0]  stat_q;
    logic [7:0]  mask_q;
    logic        run_q;
    logic        run_d;
    logic        dir_q;
    logic        dir_d;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic [16:0] div_q;
    logic [16:0] div_lim;
    logic [1:0]  idx_q;
    logic        off_q;
    logic        off_d;
    logic        sen0_q;
    logic        sen1_q;
    logic        ctrl_wr;
    logic        start;
    logic        estop;
    logic        nstop;
    logic        evt0;
    logic        evt1;
    logic        evt;
    logic        tick;
    logic        last;
    logic        moving;
    logic        in_ramp;
    srpc_state_t st_q;
    srpc_state_t st_d;

    // Bus slave: writes land in the data phase, reads take one wait state
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            wr_pend_q <= 1'b0;
            rd_wait_q <= 1'b0;
            addr_q    <= 8'h00;
        end else begin
            rd_wait_q <= 1'b0;
            if (HREADY) begin
                wr_pend_q <= HSEL && HTRANS[1] && HWRITE;
                rd_wait_q <= HSEL && HTRANS[1] && !HWRITE;
                addr_q    <= HADDR[7:0];
            end else if (rd_wait_q) begin
                wr_pend_q <= 1'b0;
            end
        end
    end

    assign HREADYOUT = !rd_wait_q;
    assign HRESP     = 1'b0;
    assign HRDATA    = rdata_q;
    assign ctrl_wr   = wr_pend_q && (addr_q == CTRL_OFS);

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_wait_q) begin
            unique case (addr_q)
                CTRL_OFS:   rdata_q <= {24'h000000, run_q, 1'b0, ctrl_q[5:0] & 6'h1f};
                STEPS_OFS:  rdata_q <= {16'h0000, steps_q};
                EXTRA_OFS:  rdata_q <= {24'h000000, extra_q};
                PERIOD_OFS: rdata_q <= {16'h0000, period_q};
                RAMP_OFS:   rdata_q <= {24'h000000, ramp_q};
                STAT_OFS:   rdata_q <= {24'h000000, stat_q};
                MASK_OFS:   rdata_q <= {24'h000000, mask_q};
                STATE_OFS:  rdata_q <= {27'h0000000, off_q, dir_q, st_q};
                default:    rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ctrl_q   <= CTRL_RST;
            steps_q  <= STEPS_RST;
            extra_q  <= EXTRA_RST;
            period_q <= PERIOD_RST;
            ramp_q   <= RAMP_RST;
            mask_q   <= MASK_RST;
        end else if (wr_pend_q) begin
            unique case (addr_q)
                CTRL_OFS:   ctrl_q   <= HWDATA[7:0];
                STEPS_OFS:  steps_q  <= HWDATA[15:0];
                EXTRA_OFS:  extra_q  <= HWDATA[7:0];
                PERIOD_OFS: period_q <= HWDATA[15:0];
                RAMP_OFS:   ramp_q   <= HWDATA[7:0];
                MASK_OFS:   mask_q   <= HWDATA[7:0];
                default:    ;
            endcase
        end
    end

    // Stop and start requests, sensor edge events and state decodes
    assign start   = ctrl_wr && HWDATA[RUN_BIT] && (st_q == SRPC_IDLE);
    assign estop   = (ctrl_wr && HWDATA[ESTOP_BIT]) || WDOG_STOP;
    assign nstop   = ctrl_wr && !HWDATA[RUN_BIT] && run_q;
    assign evt0    = SENSOR_0 && !sen0_q;
    assign evt1    = SENSOR_1 && !sen1_q;
    assign evt     = (evt0 && mask_q[SEN0_FLAG]) || (evt1 && mask_q[SEN1_FLAG]);
    assign moving  = (st_q != SRPC_IDLE);
    assign in_ramp = (st_q == SRPC_RUP) || (st_q == SRPC_RDN);
    assign last    = (cnt_q <= 16'h0001);

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            sen0_q <= 1'b0;
            sen1_q <= 1'b0;
        end else begin
            sen0_q <= SENSOR_0;
            sen1_q <= SENSOR_1;
        end
    end

    // Step rate: ramp steps take 2*period_q+1 clocks, other steps period_q+1 clocks
    assign div_lim = in_ramp ? {period_q, 1'b0} : {1'b0, period_q};
    assign tick    = moving && (div_q >= div_lim);

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            div_q <= 17'h00000;
        end else if (tick || (st_d != st_q)) begin
            div_q <= 17'h00000;
        end else if (moving) begin
            div_q <= div_q + 17'h00001;
        end
    end

    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        dir_d = dir_q;
        off_d = off_q;
        if (st_q == SRPC_IDLE) begin
            if (start) begin
                st_d  = HWDATA[RUP_BIT] ? SRPC_RUP : SRPC_RUN;
                cnt_d = HWDATA[RUP_BIT] ? {8'h00, ramp_q} : steps_q;
                dir_d = HWDATA[DIR_BIT];
                off_d = 1'b0;
            end
        end else if (estop) begin
            st_d = SRPC_IDLE;
            off_d = WDOG_STOP;
        end else if (nstop && (st_q != SRPC_RDN)) begin
            st_d  = ctrl_q[RDN_BIT] ? SRPC_RDN : SRPC_IDLE;
            cnt_d = {8'h00, ramp_q};
        end else begin
            unique case (st_q)
                SRPC_RUP: begin
                    if (tick) begin
                        st_d  = last ? SRPC_RUN : SRPC_RUP;
                        cnt_d = last ? steps_q : cnt_q - 16'h0001;
                    end
                end
                SRPC_RUN: begin
                    if (evt && ctrl_q[EXTRA_BIT] && (extra_q != 8'h00)) begin
                        st_d  = SRPC_EXTRA;
                        cnt_d = {8'h00, extra_q};
                    end else if (evt && ctrl_q[REV_BIT]) begin
                        dir_d = !dir_q;
                        cnt_d = steps_q;
                    end else if (tick) begin
                        st_d  = last ? (ctrl_q[RDN_BIT] ? SRPC_RDN : SRPC_IDLE) : SRPC_RUN;
                        cnt_d = last ? {8'h00, ramp_q} : cnt_q - 16'h0001;
                    end
                end
                SRPC_EXTRA: begin
                    if (tick) begin
                        st_d  = last ? SRPC_RUN : SRPC_EXTRA;
                        cnt_d = last ? steps_q : cnt_q - 16'h0001;
                        dir_d = (last && ctrl_q[REV_BIT]) ? !dir_q : dir_q;
                    end
                end
                SRPC_RDN: begin
                    if (tick) begin
                        st_d  = last ? SRPC_IDLE : SRPC_RDN;
                        cnt_d = cnt_q - 16'h0001;
                    end
                end
                default: st_d = SRPC_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st_q  <= SRPC_IDLE;
            cnt_q <= 16'h0000;
            dir_q <= 1'b0;
            off_q <= 1'b0;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            dir_q <= dir_d;
            off_q <= off_d;
        end
    end

    always_comb begin
        if (moving && (st_d == SRPC_IDLE)) begin
            run_d = 1'b0;
        end else if (ctrl_wr) begin
            run_d = HWDATA[RUN_BIT];
        end else begin
            run_d = run_q;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            run_q <= 1'b0;
        end else begin
            run_q <= run_d;
        end
    end

    // Wave drive phases advance one position per step
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            idx_q     <= 2'b00;
            PHASE_OUT <= 4'h0;
        end else begin
            if (tick) begin
                idx_q <= dir_q ? idx_q - 2'b01 : idx_q + 2'b01;
            end
            PHASE_OUT <= off_d ? 4'h0 : (4'h1 << idx_q);
        end
    end

    // Sticky flags, write one to clear, a new event wins over the clear
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            stat_q <= STAT_RST;
        end else begin
            stat_q <= (stat_q & ~((wr_pend_q && (addr_q == STAT_OFS)) ? HWDATA[7:0] : 8'h00))
                      | {3'b000, run_q && !run_d, 2'b00, evt1, evt0};
        end
    end

    assign IRQ = |(stat_q & mask_q);

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_ramp_no_turn: assert property ((in_ramp && !estop) |=> $stable(dir_q))
        else $error("direction changed during a ramp");
    a_estop_halt: assert property ((estop && moving) |=> (st_q == SRPC_IDLE))
        else $error("emergency stop did not halt");
    a_wdog_zero: assert property ((WDOG_STOP && moving) |=> (PHASE_OUT == 4'h0) && !run_q)
        else $error("watchdog stop left phases on");
    a_stop_ramped: assert property ((nstop && !estop && moving && (st_q != SRPC_RDN)
        && ctrl_q[RDN_BIT]) |=> (st_q == SRPC_RDN))
        else $error("normal stop did not start ramp-down");
    a_stop_now: assert property ((nstop && !estop && moving && !ctrl_q[RDN_BIT])
        |=> (st_q == SRPC_IDLE))
        else $error("normal stop without ramp-down did not halt");
    a_rdn_keeps: assert property ((st_q == SRPC_RDN && nstop && !estop && !(tick && last))
        |=> (st_q == SRPC_RDN))
        else $error("ramp-down aborted by normal stop");
    a_rev_flip: assert property ((st_q == SRPC_RUN && evt && ctrl_q[REV_BIT]
        && !ctrl_q[EXTRA_BIT] && !estop && !nstop) |=> (dir_q != $past(dir_q)) && (cnt_q == steps_q))
        else $error("reversal missing");
    a_extra_first: assert property ((st_q == SRPC_RUN && evt && ctrl_q[EXTRA_BIT]
        && (extra_q != 8'h00) && !estop && !nstop) |=> (st_q == SRPC_EXTRA) && $stable(dir_q))
        else $error("extra steps not issued first");
    a_stop_flag: assert property ((run_q && !run_d) |=> stat_q[STOP_FLAG])
        else $error("stop flag not set");
    a_run_clear: assert property ((moving && (st_d == SRPC_IDLE) && !ctrl_wr) |=> !run_q)
        else $error("run bit not cleared after stop");

    c_reverse: cover property (st_q == SRPC_RUN && evt && ctrl_q[REV_BIT]);
    c_extra: cover property (st_q == SRPC_EXTRA ##1 st_q == SRPC_RUN);
    c_rdn_done: cover property (st_q == SRPC_RDN ##1 st_q == SRPC_IDLE);
    c_estop_rup: cover property (st_q == SRPC_RUP && estop);
endmodule // srpc_top

// ==== verilog/srpc_pkg.sv ====
package srpc_pkg;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STEPS_OFS  = 8'h04;
    localparam logic [7:0] EXTRA_OFS  = 8'h08;
    localparam logic [7:0] PERIOD_OFS = 8'h0c;
    localparam logic [7:0] RAMP_OFS   = 8'h10;
    localparam logic [7:0] STAT_OFS   = 8'h14;
    localparam logic [7:0] MASK_OFS   = 8'h18;
    localparam logic [7:0] STATE_OFS  = 8'h1c;
    // Control register fields
    localparam int RUN_BIT    = 7;
    localparam int ESTOP_BIT  = 5;
    localparam int DIR_BIT    = 4;
    localparam int EXTRA_BIT  = 3;
    localparam int REV_BIT    = 2;
    localparam int RDN_BIT    = 1;
    localparam int RUP_BIT    = 0;
    // Interrupt flag fields
    localparam int SEN0_FLAG  = 0;
    localparam int SEN1_FLAG  = 1;
    localparam int STOP_FLAG  = 4;
    // Reset values
    localparam logic [7:0]  CTRL_RST   = 8'h00;
    localparam logic [15:0] STEPS_RST  = 16'h0010;
    localparam logic [7:0]  EXTRA_RST  = 8'h04;
    localparam logic [15:0] PERIOD_RST = 16'h0064;
    localparam logic [7:0]  RAMP_RST   = 8'h08;
    localparam logic [7:0]  STAT_RST   = 8'h00;
    localparam logic [7:0]  MASK_RST   = 8'h00;

    typedef enum logic [2:0] {
        SRPC_IDLE  = 3'b000,
        SRPC_RUP   = 3'b001,
        SRPC_RUN   = 3'b010,
        SRPC_EXTRA = 3'b011,
        SRPC_RDN   = 3'b100
    } srpc_state_t;
endpackage

// ==== bench/srpc_motor_model.sv ====
module srpc_motor_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [3:0] phase,
    input  wire logic [1:0] fire,
    output logic      [1:0] sensor,
    output int              fwd,
    output int              rev
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] last_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sensor <= 2'b00;
        end else begin
            sensor <= fire;
        end
    end
    // Rotor follows the wave drive; ascending index counts as forward
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            last_q <= 4'h0;
            fwd    <= 0;
            rev    <= 0;
        end else begin
            last_q <= phase;
            if (last_q != 4'h0 && phase === {last_q[2:0], last_q[3]}) begin
                fwd <= fwd + 1;
            end else if (last_q != 4'h0 && phase === {last_q[0], last_q[3:1]}) begin
                rev <= rev + 1;
            end
        end
    end
endmodule // srpc_motor_model

// ==== bench/test_stepper_run_priority_control.sv ====
module test_stepper_run_priority_control
    import srpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst, hsel, hwrite, wdog, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0]  htrans, fire, sensor;
    logic [2:0]  hsize;
    logic [3:0]  phase;
    logic [7:0]  go [4] = '{8'h83, 8'h83, 8'h81, 8'h83};
    logic [7:0]  st [4] = '{8'ha3, 8'h03, 8'h01, 8'h23};
    int          fwd, rev, i, f0;
    int          failures = 0, check_count = 0, cyc = 0, seed = 66;

    srpc_top uut (
        .CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
        .SENSOR_0(sensor[0]), .SENSOR_1(sensor[1]), .WDOG_STOP(wdog),
        .PHASE_OUT(phase), .IRQ(irq)
    );
    srpc_motor_model motor (
        .clk(clk), .rst(rst), .phase(phase), .fire(fire), .sensor(sensor),
        .fwd(fwd), .rev(rev)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            failures++;
            final_report;
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Address phase held until ready, then data phase held until ready
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= {24'h0, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 32'h0);
    endtask

    task automatic pulse(input int k);
        fire[k] <= 1'b1;
        @(posedge clk);
        fire <= 2'b00;
        @(posedge clk);
    endtask

    task automatic wait_state(input logic [2:0] s);
        int n;
        n = 0;
        do begin
            rd(STATE_OFS);
            n++;
        end while (r[2:0] !== s && n < 300);
        chk(r[2:0], s);
    endtask

    // Emergency stop beats a ramped stop, which beats an immediate one
    function automatic logic [2:0] stop_state(input logic [7:0] g, input logic [7:0] s);
        if (s[ESTOP_BIT]) return 3'd0;
        return g[RDN_BIT] ? 3'd4 : 3'd0;
    endfunction

    initial begin
        {hsel, hwrite, wdog, fire, htrans, haddr, hwdata} = '0;
        hsize = 3'b010;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk(phase, 4'h1);
        chk(irq, 1'b0);
        chk(hresp, 1'b0);
        rd(CTRL_OFS);
        chk(r, CTRL_RST);
        rd(STEPS_OFS);
        chk(r, STEPS_RST);
        rd(8'h40);
        chk(r, 32'h0);
        $display("test reset done");
        wr(PERIOD_OFS, 32'd2 + $unsigned($random(seed)) % 2);
        wr(RAMP_OFS, 32'd8);
        wr(STEPS_OFS, 32'd40);
        wr(EXTRA_OFS, 32'd4);
        wr(MASK_OFS, 32'h13);
        f0 = fwd;
        wr(CTRL_OFS, 32'h83);
        wait_state(3'd2);
        wait_state(3'd4);
        wait_state(3'd0);
        // Let the last phase change reach the motor count
        repeat (3) @(posedge clk);
        chk(fwd - f0, 32'd56);
        rd(CTRL_OFS);
        chk(r[RUN_BIT], 1'b0);
        rd(STAT_OFS);
        chk(r[STOP_FLAG], 1'b1);
        chk(irq, 1'b1);
        wr(MASK_OFS, 32'h03);
        @(posedge clk);
        chk(irq, 1'b0);
        wr(STAT_OFS, 32'h13);
        wr(MASK_OFS, 32'h13);
        @(posedge clk);
        chk(irq, 1'b0);
        $display("test walk done");
        wr(CTRL_OFS, 32'h87);
        wait_state(3'd1);
        pulse(0);
        rd(STATE_OFS);
        chk(r, 32'h01);
        wait_state(3'd2);
        chk(r[3], 1'b0);
        repeat (2 + $unsigned($random(seed)) % 6) @(posedge clk);
        f0 = rev;
        pulse(0);
        rd(STATE_OFS);
        chk(r, 32'h0a);
        repeat (8) @(posedge clk);
        chk(rev > f0, 1'b1);
        pulse(1);
        rd(STATE_OFS);
        chk(r, 32'h02);
        wait_state(3'd4);
        wr(CTRL_OFS, 32'h07);
        rd(STATE_OFS);
        chk(r[2:0], 3'd4);
        wait_state(3'd0);
        $display("test reverse done");
        wr(CTRL_OFS, 32'h8f);
        wait_state(3'd2);
        pulse(0);
        rd(STATE_OFS);
        chk(r, 32'h03);
        wait_state(3'd2);
        chk(r[3], 1'b1);
        wr(CTRL_OFS, 32'h0f);
        wait_state(3'd4);
        wr(CTRL_OFS, 32'h0f);
        rd(STATE_OFS);
        chk(r[2:0], 3'd4);
        wr(CTRL_OFS, 32'h2f);
        rd(STATE_OFS);
        chk(r[2:0], 3'd0);
        $display("test extra done");
        for (i = 0; i < 4; i++) begin
            wr(CTRL_OFS, go[i]);
            wait_state(3'd1);
            wr(CTRL_OFS, st[i]);
            rd(STATE_OFS);
            chk(r[2:0], stop_state(go[i], st[i]));
            wait_state(3'd0);
            rd(CTRL_OFS);
            chk(r[RUN_BIT], 1'b0);
        end
        $display("test ramp stops done");
        wr(CTRL_OFS, 32'h81);
        wait_state(3'd2);
        wdog <= 1'b1;
        @(posedge clk);
        wdog <= 1'b0;
        @(posedge clk);
        chk(phase, 4'h0);
        rd(STATE_OFS);
        chk(r, 32'h10);
        $display("test watchdog done");
        final_report;
    end
endmodule // test_stepper_run_priority_control
